// ---- dwm_host_model.sv ----
// Serial host stand-in: turns a bench request into a one-cycle message strobe.
// Assumes the monitor clock; the request is raised for one cycle per message.
`timescale 1ns/1ps

module dwm_host_model (
  input  wire logic clock,
  input  wire logic send_req,
  output logic      host_msg_rx
);
  // The strobe starts low so that no message is seen before the first request.
  initial host_msg_rx = 1'b0;

  // Each request becomes exactly one received message one edge later.
  always @(posedge clock)
  begin
    host_msg_rx <= send_req;
  end
endmodule : dwm_host_model

// ---- dwm_monitor.sv ----
// Drive warning monitor: watches host link, current, restart, inputs and settings.
// Assumes terminal and run pins are asynchronous; all other inputs are on clock.
`timescale 1ns/1ps
`include "dwm_regs.svh"

module dwm_monitor #(
  parameter int unsigned CYC_PER_TICK = `DWM_TICK_PERIOD_NS / `DWM_CLK_PERIOD_NS,
  parameter int unsigned CUR_W        = 16
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             host_msg_rx,
  input  wire logic [3:0]       comm_loss_sel,
  input  wire logic [CUR_W-1:0] out_current,
  input  wire logic [CUR_W-1:0] cur_level_a,
  input  wire logic [CUR_W-1:0] cur_level_b,
  input  wire logic             retry_start,
  input  wire logic [15:0]      restart_delay_ms,
  input  wire logic [7:0]       retry_count,
  input  wire logic [7:0]       di_pin,
  input  wire logic [7:0][7:0]  di_func_sel,
  input  wire logic [1:0]       ext_fault_sel,
  input  wire logic             fwd_run_pin,
  input  wire logic             rev_run_pin,
  input  wire logic [1:0]       stop_method_sel,
  input  wire logic             range_fault_in,
  input  wire logic [15:0]      par_02_03,
  input  wire logic [15:0]      par_02_06,
  input  wire logic [15:0]      par_02_22,
  input  wire logic [15:0]      par_02_25,
  input  wire logic [15:0]      vf1_max,
  input  wire logic [15:0]      vf1_base,
  input  wire logic [15:0]      vf1_mid,
  input  wire logic [15:0]      vf1_min,
  input  wire logic [15:0]      vf2_max,
  input  wire logic [15:0]      vf2_base,
  input  wire logic [15:0]      vf2_mid,
  input  wire logic [15:0]      vf2_min,
  input  wire logic [3:0]       pid_target_src,
  input  wire logic [3:0]       pid_fb_src,
  input  wire logic [3:0]       pid_mode_sel,
  input  wire logic             pid_reverse_allow,
  input  wire logic [3:0]       pid_out_mode,
  output logic                  comm_loss_warning,
  output logic                  current_limit_a_warning,
  output logic                  current_limit_b_warning,
  output logic                  retry_warning,
  output logic                  emergency_stop_warning,
  output logic                  terminal1_ext_fault,
  output logic                  terminal2_ext_fault,
  output logic                  terminal3_ext_fault,
  output logic                  terminal4_ext_fault,
  output logic                  terminal5_ext_fault,
  output logic                  terminal6_ext_fault,
  output logic                  terminal7_ext_fault,
  output logic                  terminal8_ext_fault,
  output logic                  ext_fault_trip,
  output logic                  direction_conflict_warning,
  output logic                  stop_request,
  output logic [1:0]            stop_method,
  output logic                  range_check_warning,
  output logic                  input_assignment_warning,
  output logic                  vf_curve_warning,
  output logic                  pid_select_warning,
  output logic [11:0]           flash_display
);

  logic tick;   // One cycle pulse per millisecond.
  logic blink;  // Blink phase for flashing display codes.

  // Shared time base for every timer and for the blink rate.
  dwm_tick_gen #(
    .CYC_PER_TICK (CYC_PER_TICK)
  ) u_tick (
    .clock       (clock),
    .reset       (reset),
    .tick_ms     (tick),
    .blink_phase (blink)
  );

  // Two stage synchroniser plus a history stage for edge detection.
  logic [9:0] sync1_ff;
  logic [9:0] sync2_ff;
  logic [9:0] hist_ff;
  logic [9:0] nxt_sync1;
  logic [9:0] nxt_sync2;
  logic [9:0] nxt_hist;

  // Capture the pins; only the second stage and history are read by logic.
  always_comb
  begin
    nxt_sync1 = {fwd_run_pin, rev_run_pin, di_pin};
    nxt_sync2 = sync1_ff;
    nxt_hist  = sync2_ff;
  end

  // Register the synchroniser.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sync1_ff <= 10'h000;
      sync2_ff <= 10'h000;
      hist_ff  <= 10'h000;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      hist_ff  <= nxt_hist;
    end
  end

  logic [7:0] di;        // Synchronised terminal levels.
  logic       fwd;       // Synchronised forward run.
  logic       rev;       // Synchronised reverse run.
  logic       fwd_rise;  // Forward run has just become active.
  logic       rev_rise;  // Reverse run has just become active.
  assign di       = sync2_ff[7:0];
  assign rev      = sync2_ff[8];
  assign fwd      = sync2_ff[9];
  assign rev_rise = sync2_ff[8] & ~hist_ff[8];
  assign fwd_rise = sync2_ff[9] & ~hist_ff[9];

  // Per terminal function decode and pairwise duplicate search.
  logic [7:0]  is_es, is_ef, is_up, is_dn, is_ramp, is_ssm, is_sss, is_2w, is_3w;
  logic [7:0]  ef_warn, ef_trip;
  logic [63:0] dup;

  for (genvar i = 0; i < 8; i++)
  begin : g_term
    assign is_es[i]   = di_func_sel[i] == `DWM_FN_EMERG_STOP;
    assign is_ef[i]   = (di_func_sel[i] == `DWM_FN_EXT_FAULT_A) ||
                        (di_func_sel[i] == `DWM_FN_EXT_FAULT_B);
    assign is_up[i]   = di_func_sel[i] == `DWM_FN_UP;
    assign is_dn[i]   = di_func_sel[i] == `DWM_FN_DOWN;
    assign is_ramp[i] = di_func_sel[i] == `DWM_FN_RAMP_SEL;
    assign is_ssm[i]  = di_func_sel[i] == `DWM_FN_SS_MAX;
    assign is_sss[i]  = di_func_sel[i] == `DWM_FN_SS_SET;
    assign is_2w[i]   = di_func_sel[i] == `DWM_FN_RUN_2WIRE;
    assign is_3w[i]   = di_func_sel[i] == `DWM_FN_RUN_3WIRE;
    // A fault input only warns under warn-and-continue handling.
    assign ef_warn[i] = is_ef[i] & di[i] & (ext_fault_sel == `DWM_EXT_SEL_WARN);  // see [RL7]
    // Any other handling raises the external fault trip instead.
    assign ef_trip[i] = is_ef[i] & di[i] & (ext_fault_sel != `DWM_EXT_SEL_WARN);  // see [RL8]
    for (genvar j = 0; j < 8; j++)
    begin : g_pair
      // Same function twice, ignoring fault and unused codes.
      assign dup[i*8+j] = (j > i) && (di_func_sel[i] == di_func_sel[j]) && !is_ef[i] &&
                          (di_func_sel[i] != `DWM_FN_UNUSED);  // see [RL12]
    end
  end

  // Millisecond timers: host silence and age of each run command.
  logic [15:0] comm_cnt_ff, fwd_age_ff, rev_age_ff;
  logic [15:0] nxt_comm_cnt, nxt_fwd_age, nxt_rev_age;
  logic        conflict_ff;
  logic        nxt_conflict;

  // Advance timers and judge a forward/reverse clash.
  always_comb
  begin
    nxt_comm_cnt = comm_cnt_ff;
    nxt_fwd_age  = fwd_age_ff;
    nxt_rev_age  = rev_age_ff;
    if (host_msg_rx)
      nxt_comm_cnt = 16'h0000;
    else if (tick && comm_cnt_ff != 16'hFFFF)
      nxt_comm_cnt = comm_cnt_ff + 16'h0001;
    if (fwd_rise)
      nxt_fwd_age = 16'h0000;
    else if (tick && fwd_age_ff != 16'hFFFF)
      nxt_fwd_age = fwd_age_ff + 16'h0001;
    if (rev_rise)
      nxt_rev_age = 16'h0000;
    else if (tick && rev_age_ff != 16'hFFFF)
      nxt_rev_age = rev_age_ff + 16'h0001;
    // The clash holds while both commands stay on, and no longer.
    nxt_conflict = conflict_ff;
    if (!(fwd && rev))
      nxt_conflict = 1'b0;  // see [RL22]
    else if ((fwd_rise && (rev_rise || rev_age_ff < `DWM_DIR_WINDOW_MS)) ||
             (rev_rise && fwd_age_ff < `DWM_DIR_WINDOW_MS))
      nxt_conflict = 1'b1;  // see [RL9]
  end

  // Register timers.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      comm_cnt_ff <= 16'h0000;
      fwd_age_ff  <= 16'hFFFF;
      rev_age_ff  <= 16'hFFFF;
      conflict_ff <= 1'b0;
    end
    else
    begin
      comm_cnt_ff <= nxt_comm_cnt;
      fwd_age_ff  <= nxt_fwd_age;
      rev_age_ff  <= nxt_rev_age;
      conflict_ff <= nxt_conflict;
    end
  end

  // Automatic restart sequencer.
  dwm_pkg::dwm_retry_t retry_st_ff, nxt_retry_st;
  logic [15:0]         retry_ms_ff, nxt_retry_ms;
  logic                retry_armed;
  assign retry_armed = (restart_delay_ms != 16'h0000) || (retry_count != 8'h00);  // see [RL5]

  // Hold the retry state until the restart delay has run out.
  always_comb
  begin
    nxt_retry_st = retry_st_ff;
    nxt_retry_ms = retry_ms_ff;
    case (retry_st_ff)
      dwm_pkg::DWM_RETRY_IDLE:
      begin
        nxt_retry_ms = 16'h0000;
        if (retry_start && retry_armed)
          nxt_retry_st = dwm_pkg::DWM_RETRY_HOLD;  // see [RL5]
      end
      dwm_pkg::DWM_RETRY_HOLD:
      begin
        if (retry_ms_ff >= restart_delay_ms)
          nxt_retry_st = dwm_pkg::DWM_RETRY_IDLE;  // see [RL4]
        else if (tick)
          nxt_retry_ms = retry_ms_ff + 16'h0001;
      end
      default:
      begin
        nxt_retry_st = dwm_pkg::DWM_RETRY_IDLE;
      end
    endcase
  end

  // Register the sequencer.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      retry_st_ff <= dwm_pkg::DWM_RETRY_IDLE;
      retry_ms_ff <= 16'h0000;
    end
    else
    begin
      retry_st_ff <= nxt_retry_st;
      retry_ms_ff <= nxt_retry_ms;
    end
  end

  // Configuration checks, combinational from the settings.
  logic assign_err, vf1_bad, vf2_bad, pid_err, pid_mode_on;
  assign assign_err  = (|dup) ||                                           // see [RL12]
                       ((|is_up) != (|is_dn)) ||                           // see [RL13]
                       ((|is_up) && (|is_dn) && (|is_ramp)) ||             // see [RL14]
                       ((|is_ssm) && (|is_sss)) ||                         // see [RL15]
                       ((|is_2w) && (|is_3w));                             // see [RL16]
  assign vf1_bad     = !((vf1_max > vf1_base) && (vf1_base > vf1_mid) &&
                         (vf1_mid > vf1_min));                             // see [RL17]
  assign vf2_bad     = !((vf2_max > vf2_base) && (vf2_base > vf2_mid) &&
                         (vf2_mid > vf2_min));                             // see [RL18]
  assign pid_mode_on = (pid_mode_sel == `DWM_PID_MODE_ONE) || (pid_mode_sel == `DWM_PID_MODE_TWO);
  assign pid_err     = ((pid_target_src == `DWM_PID_SRC_AIN1) &&
                        (pid_fb_src == `DWM_PID_SRC_AIN1)) ||              // see [RL19]
                       ((pid_target_src == `DWM_PID_SRC_AIN2) &&
                        (pid_fb_src == `DWM_PID_SRC_AIN2)) ||              // see [RL19]
                       (pid_mode_on && pid_reverse_allow) ||               // see [RL20]
                       (pid_mode_on && pid_out_mode[`DWM_PID_OUT_PLUS_BIT]);  // see [RL21]

  // Registered warning outputs; each follows its cause without latching.
  logic [10:0] warn_ff, nxt_warn;
  logic [7:0]  efw_ff, nxt_efw;
  logic [11:0] flash_ff, nxt_flash;
  logic [1:0]  method_ff, nxt_method;

  // Compute every warning from its present cause.
  always_comb
  begin
    nxt_warn[0]  = (comm_loss_sel == `DWM_COMM_SEL_WARN) &&
                   (comm_cnt_ff >= `DWM_COMM_LOSS_MS);                     // see [RL1]
    nxt_warn[1]  = out_current >= cur_level_a;                             // see [RL2]
    nxt_warn[2]  = out_current >= cur_level_b;                             // see [RL3]
    nxt_warn[3]  = retry_st_ff == dwm_pkg::DWM_RETRY_HOLD;                 // see [RL4]
    nxt_warn[4]  = |(is_es & di);                                          // see [RL6]
    nxt_warn[5]  = |ef_trip;                                               // see [RL8]
    nxt_warn[6]  = conflict_ff;                                            // see [RL9]
    nxt_warn[7]  = range_fault_in ||                                       // see [RL10]
                   (par_02_03 > par_02_06) || (par_02_22 > par_02_25);     // see [RL11]
    nxt_warn[8]  = assign_err;
    nxt_warn[9]  = vf1_bad || vf2_bad;
    nxt_warn[10] = pid_err;
    nxt_efw      = ef_warn;                                                // see [RL22]
    nxt_method   = stop_method_sel;
    // Flashing codes are shown only in the lit half of the blink.
    nxt_flash    = {nxt_warn[0], nxt_warn[3], nxt_warn[4], ef_warn, conflict_ff} &
                   {12{blink}};                                            // see [RL23]
  end

  // Register the outputs.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      warn_ff   <= 11'h000;
      efw_ff    <= 8'h00;
      flash_ff  <= 12'h000;
      method_ff <= 2'h0;
    end
    else
    begin
      warn_ff   <= nxt_warn;
      efw_ff    <= nxt_efw;
      flash_ff  <= nxt_flash;
      method_ff <= nxt_method;
    end
  end

  assign comm_loss_warning          = warn_ff[0];
  assign current_limit_a_warning    = warn_ff[1];
  assign current_limit_b_warning    = warn_ff[2];
  assign retry_warning              = warn_ff[3];
  assign emergency_stop_warning     = warn_ff[4];
  assign ext_fault_trip             = warn_ff[5];
  assign direction_conflict_warning = warn_ff[6];
  assign stop_request               = warn_ff[6];
  assign stop_method                = method_ff;
  assign range_check_warning        = warn_ff[7];
  assign input_assignment_warning   = warn_ff[8];
  assign vf_curve_warning           = warn_ff[9];
  assign pid_select_warning         = warn_ff[10];
  assign {terminal8_ext_fault, terminal7_ext_fault, terminal6_ext_fault, terminal5_ext_fault,
          terminal4_ext_fault, terminal3_ext_fault, terminal2_ext_fault,
          terminal1_ext_fault}      = efw_ff;
  assign flash_display              = flash_ff;

  // Checks on the monitor's own behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_retry_enter;
    (retry_st_ff == dwm_pkg::DWM_RETRY_IDLE) && retry_start && retry_armed;
  endsequence
  sequence s_retry_shown;
    ##1 (retry_st_ff == dwm_pkg::DWM_RETRY_HOLD) ##1 retry_warning;
  endsequence

  a_comm_timeout: assert property (  // see [RL1]
    (comm_loss_sel == `DWM_COMM_SEL_WARN) && (comm_cnt_ff >= `DWM_COMM_LOSS_MS)
    && !host_msg_rx |=> comm_loss_warning)
    else $error("Host silence did not raise the link warning.");
  a_comm_msg_clear: assert property (host_msg_rx |=> ##1 !comm_loss_warning)  // see [RL1]
    else $error("Link warning stayed after a host message.");
  a_limit_a: assert property (  // see [RL2]
    (out_current >= cur_level_a) |=> current_limit_a_warning)
    else $error("Current limit A warning missing.");
  a_limit_b_clear: assert property (  // see [RL3]
    (out_current < cur_level_b) |=> !current_limit_b_warning)
    else $error("Current limit B warning without cause.");
  a_retry_show: assert property (s_retry_enter |-> s_retry_shown)  // see [RL4]
    else $error("Retry warning not shown after restart request.");
  a_retry_gate: assert property (  // see [RL5]
    (retry_st_ff == dwm_pkg::DWM_RETRY_IDLE) && !retry_armed |=> ##1 !retry_warning)
    else $error("Retry engaged with zero delay and count.");
  a_estop_raise: assert property ((|(is_es & di)) |=> emergency_stop_warning)  // see [RL6]
    else $error("Emergency stop input ignored.");
  a_ext_no_trip: assert property (  // see [RL8]
    (ext_fault_sel == `DWM_EXT_SEL_WARN) |=> !ext_fault_trip)
    else $error("External fault tripped under warn-only handling.");
  a_dir_stop: assert property (direction_conflict_warning |-> stop_request &&  // see [RL9]
    (stop_method == $past(stop_method_sel)))
    else $error("Direction clash without stop request.");
  a_vf_order: assert property ((vf1_bad || vf2_bad) |=> vf_curve_warning)  // see [RL17]
    else $error("Bad V/f order not flagged.");
  a_warn_release: assert property (!(fwd && rev) |=> ##1 !direction_conflict_warning)  // see [RL22]
    else $error("Direction warning latched after release.");

endmodule : dwm_monitor

// ---- dwm_pkg.sv ----
// Types shared by the drive warning monitor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dwm_pkg;

  // Automatic restart sequencer states, Gray coded along idle to hold.
  typedef enum logic [1:0]
  {
    DWM_RETRY_IDLE = 2'h0,
    DWM_RETRY_HOLD = 2'h1
  } dwm_retry_t;

endpackage : dwm_pkg

// ---- dwm_regs.svh ----
// Constants for the drive warning monitor: codes, selections and timing.
// Assumes a single 50 MHz clock; included by bare name by the monitor and tick generator files.
//
// Summary of operation
// [RL1] Host silent two seconds with selection three: warn.
// [RL2] Current at level A raises limit A warning.
// [RL3] Current at level B raises limit B warning.
// [RL4] Retry warning held until restart delay expires.
// [RL5] Retry engages only if delay or count nonzero.
// [RL6] Input coded fourteen and asserted: emergency stop.
// [RL7] Per terminal fault: code 25/68, asserted, select two.
// [RL8] Fault select two warns only, drive keeps running.
// [RL9] Forward/reverse within half second: warn and stop.
// [RL10] Out of range parameter raises range warning.
// [RL11] Range error when 02-03>02-06 or 02-22>02-25.
// [RL12] Duplicate input functions raise assignment warning.
// [RL13] Up without down, or reverse, raises warning.
// [RL14] Up/down with ramp select together raises warning.
// [RL15] Both speed search codes assigned raises warning.
// [RL16] Two-wire and three-wire together raises warning.
// [RL17] First V/f curve must be strictly descending.
// [RL18] Second V/f curve must be strictly descending.
// [RL19] PID target and feedback same analog input: warn.
// [RL20] PID mode one/two with reverse allowed: warn.
// [RL21] PID mode one/two with output plus target: warn.
// [RL22] Warnings follow their cause and never latch.
// [RL23] Flashing warnings toggle their display at blink rate.
`ifndef DWM_REGS_SVH
`define DWM_REGS_SVH

// Clock period and the one millisecond time base.
`define DWM_CLK_PERIOD_NS   20
`define DWM_TICK_PERIOD_NS  1000000
// Host silence limit, forward/reverse window and blink half period, in ms.
`define DWM_COMM_LOSS_MS    16'h07D0
`define DWM_DIR_WINDOW_MS   16'h01F4
`define DWM_BLINK_HALF_MS   16'h00FA
// Communication loss selection that enables the warning.
`define DWM_COMM_SEL_WARN   4'h3
// External fault handling selection meaning warn and continue.
`define DWM_EXT_SEL_WARN    2'h2
// Input terminal function codes.
`define DWM_FN_RUN_2WIRE    8'h00
`define DWM_FN_UP           8'h08
`define DWM_FN_DOWN         8'h09
`define DWM_FN_RAMP_SEL     8'h0B
`define DWM_FN_EMERG_STOP   8'h0E
`define DWM_FN_SS_MAX       8'h13
`define DWM_FN_RUN_3WIRE    8'h1A
`define DWM_FN_EXT_FAULT_A  8'h19
`define DWM_FN_SS_SET       8'h22
`define DWM_FN_EXT_FAULT_B  8'h44
`define DWM_FN_UNUSED       8'h0F
// PID source and mode codes.
`define DWM_PID_SRC_AIN1    4'h1
`define DWM_PID_SRC_AIN2    4'h2
`define DWM_PID_MODE_ONE    4'h1
`define DWM_PID_MODE_TWO    4'h2
`define DWM_PID_OUT_PLUS_BIT 3

`endif

// ---- dwm_tick_gen.sv ----
// Millisecond tick and blink phase generator for the warning monitor.
// Assumes one free running clock and a synchronous active high reset.
`timescale 1ns/1ps
`include "dwm_regs.svh"

module dwm_tick_gen #(
  parameter int unsigned CYC_PER_TICK = `DWM_TICK_PERIOD_NS / `DWM_CLK_PERIOD_NS
) (
  input  wire logic clock,
  input  wire logic reset,
  output logic      tick_ms,
  output logic      blink_phase
);

  localparam int unsigned CW = $clog2(CYC_PER_TICK + 1);

  logic [CW-1:0] cyc_ff;     // Clock cycles within the current millisecond.
  logic [CW-1:0] nxt_cyc;
  logic [15:0]   ms_ff;      // Milliseconds within the current blink half.
  logic [15:0]   nxt_ms;
  logic          tick_ff;    // One cycle pulse per millisecond.
  logic          nxt_tick;
  logic          blink_ff;   // Display phase for flashing codes.
  logic          nxt_blink;

  // Count cycles into milliseconds and milliseconds into blink halves.
  always_comb
  begin
    nxt_tick  = 1'b0;
    nxt_cyc   = cyc_ff + 1'b1;
    nxt_ms    = ms_ff;
    nxt_blink = blink_ff;
    if (cyc_ff == CW'(CYC_PER_TICK - 1))
    begin
      // Close the millisecond and advance the blink timer.
      nxt_cyc  = '0;
      nxt_tick = 1'b1;
      if (ms_ff == `DWM_BLINK_HALF_MS - 16'h0001)
      begin
        nxt_ms    = 16'h0000;
        nxt_blink = ~blink_ff;  // see [RL23]
      end
      else
      begin
        nxt_ms = ms_ff + 16'h0001;
      end
    end
  end

  // Register the time base.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cyc_ff   <= '0;
      ms_ff    <= 16'h0000;
      tick_ff  <= 1'b0;
      blink_ff <= 1'b0;
    end
    else
    begin
      cyc_ff   <= nxt_cyc;
      ms_ff    <= nxt_ms;
      tick_ff  <= nxt_tick;
      blink_ff <= nxt_blink;
    end
  end

  assign tick_ms     = tick_ff;
  assign blink_phase = blink_ff;

endmodule : dwm_tick_gen

// ---- test_drive_warning_monitor.sv ----
// Self-checking bench for the drive warning monitor, with a shortened tick.
// Assumes the design files and the host model are compiled before this file.
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t %s", $time, m); end end

module test_drive_warning_monitor;
  logic clock = 1'b0, reset = 1'b1, send_req = 1'b0, retry_start = 1'b0;
  logic [3:0] comm_loss_sel = 4'h0, pid_target_src = 4'h0, pid_fb_src = 4'h0;
  logic [3:0] pid_mode_sel = 4'h0, pid_out_mode = 4'h0;
  logic [15:0] out_current = 16'h0000, cur_level_a = 16'h0100, cur_level_b = 16'h0200;
  logic [15:0] restart_delay_ms = 16'h0000, par_02_03 = 16'h0001, par_02_06 = 16'h0002;
  logic [15:0] par_02_22 = 16'h0001, par_02_25 = 16'h0002;
  logic [15:0] vf1_max = 16'h0400, vf1_base = 16'h0300, vf1_mid = 16'h0200;
  logic [15:0] vf1_min = 16'h0100, vf2_max = 16'h0400, vf2_base = 16'h0300;
  logic [15:0] vf2_mid = 16'h0200, vf2_min = 16'h0100;
  logic [7:0] retry_count = 8'h00, di_pin = 8'h00;
  logic [7:0][7:0] di_func_sel = {8{8'h0F}};
  logic [1:0] ext_fault_sel = 2'h2, stop_method_sel = 2'h2, stop_method;
  logic fwd_run_pin = 1'b0, rev_run_pin = 1'b0, range_fault_in = 1'b0;
  logic pid_reverse_allow = 1'b0, host_msg_rx, comm_loss_warning, retry_warning;
  logic current_limit_a_warning, current_limit_b_warning, emergency_stop_warning;
  logic terminal1_ext_fault, terminal2_ext_fault, terminal3_ext_fault, terminal4_ext_fault;
  logic terminal5_ext_fault, terminal6_ext_fault, terminal7_ext_fault, terminal8_ext_fault;
  logic ext_fault_trip, direction_conflict_warning, stop_request, range_check_warning;
  logic input_assignment_warning, vf_curve_warning, pid_select_warning;
  logic [11:0] flash_display;
  int failures = 0, num_checks = 0;

  // Four clocks per tick keep the millisecond counts short.
  dwm_monitor #(.CYC_PER_TICK(4)) i_dwm_monitor (.*);
  dwm_host_model i_dwm_host_model (.*);

  // Free running 50 MHz clock.
  initial forever #10 clock = ~clock;

  // Waits whole cycles, then steps past the edge so outputs are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Current levels A and B are judged independently.
  task automatic t_current;
    @(posedge clock) out_current <= 16'h0100;
    tick(2);
    `CHK(current_limit_a_warning, 1'b1, "level A not flagged")
    `CHK(current_limit_b_warning, 1'b0, "level B early")
    @(posedge clock) out_current <= 16'h0200;
    tick(2);
    `CHK(current_limit_b_warning, 1'b1, "level B not flagged")
    @(posedge clock) out_current <= 16'h0000;
    tick(2);
    `CHK({current_limit_a_warning, current_limit_b_warning}, 2'b00, "limit latched")
  endtask : t_current

  // Emergency stop on terminal 3, then an external fault on terminal 8.
  task automatic t_terminals;
    int lit = 0;
    @(posedge clock) begin di_func_sel[2] <= 8'h0E; di_pin <= 8'h04; end
    tick(4);
    `CHK(emergency_stop_warning, 1'b1, "stop not flagged")
    repeat (2000) begin lit += flash_display[9]; tick(1); end
    `CHK(lit, 1000, "stop not flashing")
    @(posedge clock) begin di_func_sel[7] <= 8'h44; di_pin <= 8'h80; end
    tick(4);
    `CHK(emergency_stop_warning, 1'b0, "stop latched")
    `CHK({terminal8_ext_fault, ext_fault_trip}, 2'b10, "fault should only warn")
    @(posedge clock) ext_fault_sel <= 2'h1;
    tick(3);
    `CHK({terminal8_ext_fault, ext_fault_trip}, 2'b01, "fault handling wrong")
    @(posedge clock) begin di_func_sel[7] <= 8'h19; ext_fault_sel <= 2'h2; end
    tick(2);
    `CHK({terminal8_ext_fault, ext_fault_trip}, 2'b10, "code 25 not warned")
    @(posedge clock) begin di_pin <= 8'h00; di_func_sel[2] <= 8'h0F; end
    tick(4);
    `CHK(terminal8_ext_fault, 1'b0, "fault latched")
  endtask : t_terminals

  // Settings checks: each bad value is applied, judged and removed, except the final reverse-allow and lone up pair.
  task automatic t_settings;
    @(posedge clock) par_02_22 <= 16'h0003;
    tick(2);
    `CHK(range_check_warning, 1'b1, "range not flagged")
    @(posedge clock) begin par_02_22 <= 16'h0001; vf2_mid <= 16'h0300; end
    tick(2);
    `CHK({range_check_warning, vf_curve_warning}, 2'b01, "curve not flagged")
    @(posedge clock) begin vf2_mid <= 16'h0200; di_func_sel[0] <= 8'h13; end
    @(posedge clock) di_func_sel[1] <= 8'h22;
    tick(2);
    `CHK({vf_curve_warning, input_assignment_warning}, 2'b01, "search pair")
    @(posedge clock) begin di_func_sel[0] <= 8'h0F; di_func_sel[1] <= 8'h0F; end
    @(posedge clock) begin pid_target_src <= 4'h2; pid_fb_src <= 4'h2; end
    tick(2);
    `CHK({input_assignment_warning, pid_select_warning}, 2'b01, "pid source")
    @(posedge clock) begin pid_fb_src <= 4'h1; pid_mode_sel <= 4'h2; pid_out_mode <= 4'h8; end
    tick(2);
    `CHK(pid_select_warning, 1'b1, "pid output mode")
    @(posedge clock) pid_out_mode <= 4'h7;
    tick(2);
    `CHK(pid_select_warning, 1'b0, "pid latched")
    @(posedge clock) begin pid_reverse_allow <= 1'b1; di_func_sel[4] <= 8'h08; end
    tick(2);
    `CHK({pid_select_warning, input_assignment_warning}, 2'b11, "lone up")
  endtask : t_settings

  // Forward then reverse eleven cycles apart must clash and request a stop.
  task automatic t_direction;
    @(posedge clock) fwd_run_pin <= 1'b1;
    tick(10);
    @(posedge clock) rev_run_pin <= 1'b1;
    tick(5);
    `CHK({direction_conflict_warning, stop_request}, 2'b11, "clash missed")
    `CHK(stop_method, 2'h2, "stop method")
    @(posedge clock) begin fwd_run_pin <= 1'b0; rev_run_pin <= 1'b0; end
    tick(6);
    `CHK(direction_conflict_warning, 1'b0, "clash latched")
  endtask : t_direction

  // Retry is refused with zero delay and count, then held for ten ms.
  task automatic t_retry;
    @(posedge clock) retry_start <= 1'b1;
    @(posedge clock) retry_start <= 1'b0;
    tick(1);
    `CHK(retry_warning, 1'b0, "retry with zero settings")
    @(posedge clock) begin restart_delay_ms <= 16'h000A; retry_start <= 1'b1; end
    @(posedge clock) begin retry_start <= 1'b0; retry_count <= 8'h03; end
    tick(30);
    `CHK(retry_warning, 1'b1, "retry not held")
    tick(30);
    `CHK(retry_warning, 1'b0, "retry not cleared")
    @(posedge clock) begin restart_delay_ms <= 16'h0000; retry_start <= 1'b1; end
    @(posedge clock) retry_start <= 1'b0;
    tick(1);
    `CHK(retry_warning, 1'b1, "count ignored")
  endtask : t_retry

  // Host silence of two seconds, i.e. 2000 ticks of four cycles.
  task automatic t_comm;
    @(posedge clock) send_req <= 1'b1;
    @(posedge clock) begin send_req <= 1'b0; comm_loss_sel <= 4'h3; end
    tick(7900);
    `CHK(comm_loss_warning, 1'b0, "link warning early")
    tick(200);
    `CHK(comm_loss_warning, 1'b1, "link warning missing")
    @(posedge clock) send_req <= 1'b1;
    @(posedge clock) send_req <= 1'b0;
    tick(4);
    `CHK(comm_loss_warning, 1'b0, "link warning latched")
  endtask : t_comm

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Main sequence: reset for three cycles, then every scenario in turn.
  initial
  begin
    tick(2);
    @(posedge clock) reset <= 1'b0;
    tick(2);
    t_current();
    t_terminals();
    t_settings();
    t_direction();
    t_retry();
    t_comm();
    conclude();
  end

  // Watchdog: the run needs about 10300 cycles, so 1 ms means a hang.
  initial
  begin
    #1000000;
    failures++;
    conclude();
  end
endmodule : test_drive_warning_monitor
